// file: csr_pkg.sv
// Package for the clock skew and recovery frequency register bank.
// Assumes a byte-wide register port driven by an SMBus slave elsewhere in the chip.
package csr_pkg;
  localparam logic [7:0] OFS_SKEW       = 8'h0A;
  localparam logic [7:0] OFS_REC_N      = 8'h0B;
  localparam logic [7:0] OFS_REC_SEL_M  = 8'h0C;
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam int         PROC_SKEW_LSB  = 5;
  localparam int         MEM_SKEW_LSB   = 2;
  localparam int         GFX_SKEW_LSB   = 0;
  localparam int         REC_SEL_BIT    = 7;
  localparam int         FREQ_MIN_MHZ   = 50;
  localparam int         FREQ_MAX_MHZ   = 248;
  typedef enum logic [1:0] {
    CSR_SRC_NORMAL   = 2'b00,
    CSR_SRC_STRAP    = 2'b01,
    CSR_SRC_PROGRAM  = 2'b10
  } csr_src_type;
endpackage

// file: csr_skew_if.sv
// Interface carrying the applied skew codes from the register bank to its decoder.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
interface csr_skew_if;
  logic [2:0] processor_clock_delay_code;
  logic [2:0] memory_clock_delay_code;
  logic [1:0] graphics_clock_delay_code;
  logic [3:0] proc_delay_steps;
  logic       proc_delay_late;
  logic [3:0] mem_delay_steps;
  logic       mem_delay_late;
  logic [3:0] gfx_delay_steps;
  logic       gfx_delay_late;
  modport bank (output processor_clock_delay_code, memory_clock_delay_code, graphics_clock_delay_code,
                input proc_delay_steps, proc_delay_late, mem_delay_steps, mem_delay_late,
                gfx_delay_steps, gfx_delay_late);
  modport decode (input processor_clock_delay_code, memory_clock_delay_code, graphics_clock_delay_code,
                  output proc_delay_steps, proc_delay_late, mem_delay_steps, mem_delay_late,
                  gfx_delay_steps, gfx_delay_late);
endinterface

// file: csr_skew_decode.sv
// Decoder turning skew codes into a count of 150 ps steps and a direction.
// Assumes the codes come from registers; output is combinational.
`timescale 1ns/100ps
module csr_skew_decode (
  // Skew codes in, steps out
  csr_skew_if.decode sk
);
  // Three-bit code: 0 none, 1..3 earlier by 1..3 steps, 4..7 later by 1..4 steps.
  function automatic logic [4:0] dec3(input logic [2:0] c);
    if (c == 3'h0) begin
      dec3 = 5'h00;
    end else if (!c[2]) begin
      dec3 = {1'b0, 2'b00, c[1:0]};
    end else begin
      dec3 = {1'b1, 4'({2'b00, c[1:0]} + 4'h1)};
    end
  endfunction

  always_comb begin
    {sk.proc_delay_late, sk.proc_delay_steps} = dec3(sk.processor_clock_delay_code);
    {sk.mem_delay_late, sk.mem_delay_steps}   = dec3(sk.memory_clock_delay_code);
    case (sk.graphics_clock_delay_code)
      2'b01:   {sk.gfx_delay_late, sk.gfx_delay_steps} = 5'h01;
      2'b10:   {sk.gfx_delay_late, sk.gfx_delay_steps} = 5'h11;
      2'b11:   {sk.gfx_delay_late, sk.gfx_delay_steps} = 5'h12;
      default: {sk.gfx_delay_late, sk.gfx_delay_steps} = 5'h00;
    endcase
  end
endmodule

// file: csr_regs.sv
// Skew control and recovery frequency register bank of the clock generator.
// Assumes an SMBus slave presents byte writes and reads on a simple port in clk_sys.
`timescale 1ns/100ps
module csr_regs (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // Register port from the SMBus slave
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_hit,
  // Watchdog and strap context
  input  wire logic                 watchdog_timeout,
  input  wire logic                 watchdog_enable,
  input  wire logic                 ratio_source_override,
  input  wire logic [4:0]           strap_frequency_code,
  input  wire logic [4:0]           software_frequency_code,
  // Synthesizer controls
  output logic                      recovery_mode,
  output csr_pkg::csr_src_type      proc_freq_source,
  output logic [7:0]                proc_divider_n,
  output logic [6:0]                proc_divider_m,
  output logic [4:0]                ratio_code,
  output logic                      freq_change_start,
  output logic                      range_ok,
  // Skew controls
  output logic [3:0]                proc_delay_steps,
  output logic                      proc_delay_late,
  output logic [3:0]                mem_delay_steps,
  output logic                      mem_delay_late,
  output logic [3:0]                gfx_delay_steps,
  output logic                      gfx_delay_late
);
  typedef csr_pkg::csr_src_type csr_src_type;

  typedef struct packed {
    logic [7:0]  skew;
    logic [7:0]  rec_n;
    logic [7:0]  rec_sel_m;
    logic [7:0]  rdata;
    logic        hit;
    logic        locked;
    logic        start;
    csr_src_type src;
  } csr_state_type;

  csr_state_type s_q;
  csr_state_type s_d;
  csr_skew_if    sk ();

  logic wr_skew;
  logic wr_n;
  logic wr_m;

  assign wr_skew = reg_wr && (reg_addr == csr_pkg::OFS_SKEW);
  assign wr_n    = reg_wr && (reg_addr == csr_pkg::OFS_REC_N);
  assign wr_m    = reg_wr && (reg_addr == csr_pkg::OFS_REC_SEL_M);

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    if (wr_skew) begin
      s_d.skew = reg_wdata;
    end
    if (wr_n) begin
      s_d.rec_n = reg_wdata;
    end
    if (wr_m) begin
      s_d.rec_sel_m = reg_wdata;
    end
    // A time-out while locked changes nothing; the clear of enable unlocks.
    if (!watchdog_enable) begin
      s_d.locked = 1'b0;
    end else if (watchdog_timeout) begin
      s_d.locked = 1'b1;
    end
    if (watchdog_enable && watchdog_timeout && !s_q.locked) begin
      s_d.src   = s_d.rec_sel_m[csr_pkg::REC_SEL_BIT] ? csr_pkg::CSR_SRC_PROGRAM
                                                      : csr_pkg::CSR_SRC_STRAP;
      s_d.start = 1'b1;
    end else if (!s_d.locked) begin
      s_d.src = csr_pkg::CSR_SRC_NORMAL;
    end
    // Writes to N or M retune the synthesizer only while recovery is locked on the programmed source.
    if ((wr_n || wr_m) && s_q.locked && s_q.src == csr_pkg::CSR_SRC_PROGRAM) begin
      s_d.start = 1'b1;
    end
    s_d.hit = reg_rd || reg_wr ? (reg_addr == csr_pkg::OFS_SKEW || reg_addr == csr_pkg::OFS_REC_N ||
                                  reg_addr == csr_pkg::OFS_REC_SEL_M) : 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        csr_pkg::OFS_SKEW:      s_d.rdata = s_q.skew;
        csr_pkg::OFS_REC_N:     s_d.rdata = s_q.rec_n;
        csr_pkg::OFS_REC_SEL_M: s_d.rdata = s_q.rec_sel_m;
        default:                s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{skew: csr_pkg::RESET_VALUE, rec_n: csr_pkg::RESET_VALUE, rec_sel_m: csr_pkg::RESET_VALUE,
               rdata: 8'h00, hit: 1'b0, locked: 1'b0, start: 1'b0, src: csr_pkg::CSR_SRC_NORMAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign sk.processor_clock_delay_code = s_q.skew[csr_pkg::PROC_SKEW_LSB +: 3];
  assign sk.memory_clock_delay_code    = s_q.skew[csr_pkg::MEM_SKEW_LSB +: 3];
  assign sk.graphics_clock_delay_code  = s_q.skew[csr_pkg::GFX_SKEW_LSB +: 2];

  csr_skew_decode u_dec (
    .sk (sk.decode)
  );

  assign proc_delay_steps  = sk.proc_delay_steps;
  assign proc_delay_late   = sk.proc_delay_late;
  assign mem_delay_steps   = sk.mem_delay_steps;
  assign mem_delay_late    = sk.mem_delay_late;
  assign gfx_delay_steps   = sk.gfx_delay_steps;
  assign gfx_delay_late    = sk.gfx_delay_late;

  assign reg_rdata         = s_q.rdata;
  assign reg_hit           = s_q.hit;
  assign recovery_mode     = s_q.locked;
  assign proc_freq_source  = s_q.src;
  assign proc_divider_n    = s_q.rec_n;
  assign proc_divider_m    = s_q.rec_sel_m[6:0];
  assign ratio_code        = ratio_source_override ? software_frequency_code : strap_frequency_code;
  assign freq_change_start = s_q.start;
  // Coarse plausibility flag: N nonzero, M nonzero; the synthesizer clamps to 50..248 MHz.
  assign range_ok          = (s_q.rec_n != 8'h00) && (s_q.rec_sel_m[6:0] != 7'h00);

  property p_timeout_locks;
    @(posedge clk_sys) disable iff (!rst_b)
      watchdog_enable && watchdog_timeout |=> recovery_mode;
  endproperty
  a_timeout_locks: assert property (p_timeout_locks)
    else $error("time-out did not lock recovery");

  property p_unlock;
    @(posedge clk_sys) disable iff (!rst_b)
      !watchdog_enable |=> !recovery_mode && proc_freq_source == csr_pkg::CSR_SRC_NORMAL;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("enable clear did not unlock");

  property p_sel;
    @(posedge clk_sys) disable iff (!rst_b)
      watchdog_enable && watchdog_timeout && !recovery_mode && !wr_m |=>
        proc_freq_source == ($past(s_q.rec_sel_m[csr_pkg::REC_SEL_BIT]) ? csr_pkg::CSR_SRC_PROGRAM
                                                                         : csr_pkg::CSR_SRC_STRAP);
  endproperty
  a_sel: assert property (p_sel)
    else $error("wrong recovery source");

  property p_no_early;
    @(posedge clk_sys) disable iff (!rst_b)
      !recovery_mode && !watchdog_timeout |=> proc_freq_source == csr_pkg::CSR_SRC_NORMAL;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("recovery source without time-out");

  property p_retune;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_n || wr_m) && recovery_mode && proc_freq_source == csr_pkg::CSR_SRC_PROGRAM |=> freq_change_start;
  endproperty
  a_retune: assert property (p_retune)
    else $error("write did not start frequency change");

  property p_readback;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_skew ##1 reg_rd && reg_addr == csr_pkg::OFS_SKEW |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("skew readback mismatch");

  property p_proc_skew;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_skew && reg_wdata[7:5] == 3'h7 |=> proc_delay_late && proc_delay_steps == 4'h4;
  endproperty
  a_proc_skew: assert property (p_proc_skew)
    else $error("processor skew decode wrong");

  property p_gfx_skew;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_skew && reg_wdata[1:0] == 2'h1 |=> !gfx_delay_late && gfx_delay_steps == 4'h1;
  endproperty
  a_gfx_skew: assert property (p_gfx_skew)
    else $error("graphics skew decode wrong");

  property p_div;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_n |=> proc_divider_n == $past(reg_wdata);
  endproperty
  a_div: assert property (p_div)
    else $error("recovery N not applied");

  property p_ratio;
    @(posedge clk_sys) disable iff (!rst_b)
      ratio_source_override |-> ratio_code == software_frequency_code;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("override ratio not used");

  property p_range;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_n && reg_wdata == 8'h00 |=> !range_ok;
  endproperty
  a_range: assert property (p_range)
    else $error("zero N flagged in range");

  c_unlock: cover property (@(posedge clk_sys) disable iff (!rst_b) recovery_mode ##1 !recovery_mode);
  c_program_src: cover property (@(posedge clk_sys) disable iff (!rst_b)
    proc_freq_source == csr_pkg::CSR_SRC_PROGRAM);
  c_strap_src: cover property (@(posedge clk_sys) disable iff (!rst_b)
    proc_freq_source == csr_pkg::CSR_SRC_STRAP);
  c_retune: cover property (@(posedge clk_sys) disable iff (!rst_b) recovery_mode ##1 freq_change_start);
endmodule

// file: csr_host_model.sv
// SMBus host model driving byte reads and writes onto the register port of the bank.
// Assumes clk_sys is shared with the bank and every task is entered just after a rising edge.
`timescale 1ns/100ps
module csr_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // The strobe is left high so that a following write can go back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  // Released data is inverted so that a stale byte is never mistaken for a live one.
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~reg_wdata;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
  task automatic wr_pair(input logic [7:0] n, input logic [7:0] m);
    wr(8'h0B, n);
    wr(8'h0C, m);
    idle();
  endtask
endmodule

// file: clock_skew_recovery_freq_regs_tb.sv
// Self-checking bench for the skew and recovery register bank, random with a fixed seed.
// Assumes the bank and the host model share one 25 MHz clock.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module clock_skew_recovery_freq_regs_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr, reg_rd, reg_hit, watchdog_timeout, watchdog_enable, ratio_source_override;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, proc_divider_n;
  logic [4:0] strap_frequency_code, software_frequency_code, ratio_code;
  logic recovery_mode, freq_change_start, range_ok, proc_delay_late, mem_delay_late, gfx_delay_late;
  logic [6:0] proc_divider_m;
  logic [3:0] proc_delay_steps, mem_delay_steps, gfx_delay_steps;
  csr_pkg::csr_src_type proc_freq_source;
  logic [31:0] seed_q = 32'h00009D06;
  logic [31:0] r;
  logic [7:0] v, n, got;
  logic hit;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  csr_host_model u_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  csr_regs u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .watchdog_timeout(watchdog_timeout),
    .watchdog_enable(watchdog_enable), .ratio_source_override(ratio_source_override),
    .strap_frequency_code(strap_frequency_code), .software_frequency_code(software_frequency_code),
    .recovery_mode(recovery_mode), .proc_freq_source(proc_freq_source), .proc_divider_n(proc_divider_n),
    .proc_divider_m(proc_divider_m), .ratio_code(ratio_code), .freq_change_start(freq_change_start),
    .range_ok(range_ok), .proc_delay_steps(proc_delay_steps), .proc_delay_late(proc_delay_late),
    .mem_delay_steps(mem_delay_steps), .mem_delay_late(mem_delay_late), .gfx_delay_steps(gfx_delay_steps),
    .gfx_delay_late(gfx_delay_late));
  always #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed_q ^= seed_q << 13;
    seed_q ^= seed_q >> 17;
    seed_q ^= seed_q << 5;
    return seed_q;
  endfunction
  function automatic logic [4:0] skew3(input logic [2:0] c);
    return c[2] ? {1'b1, 4'(c - 3'h3)} : {2'h0, c};
  endfunction
  function automatic logic [4:0] skew2(input logic [1:0] c);
    return (c < 2'h2) ? {3'h0, c} : {1'b1, 4'(c) - 4'h1};
  endfunction
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input logic h);
    u_host.wr(a, d);
    u_host.rd(a, got, hit);
    `CHK("reg_rdata", e, got)
    `CHK("reg_hit", h, hit)
    @(posedge clk_sys);
  endtask
  // Reads the three registers back and expects the reset value in each.
  task automatic read_zero();
    for (int a = 0; a < 3; a++) begin
      u_host.rd(8'(csr_pkg::OFS_SKEW + a), got, hit);
      `CHK("reset_value", csr_pkg::RESET_VALUE, got)
      @(posedge clk_sys);
    end
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    {watchdog_timeout, watchdog_enable, ratio_source_override} = 3'h0;
    {strap_frequency_code, software_frequency_code} = 10'h000;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    read_zero();
    // The first eight patterns walk every delay code; the rest are random.
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      v = (i < 8) ? {3'(i), 3'(7 - i), 2'(i)} : r[7:0];
      wr_rd(8'h0A, v, v, 1'b1);
      `CHK("proc_skew", skew3(v[7:5]), {proc_delay_late, proc_delay_steps})
      `CHK("mem_skew", skew3(v[4:2]), {mem_delay_late, mem_delay_steps})
      `CHK("gfx_skew", skew2(v[1:0]), {gfx_delay_late, gfx_delay_steps})
    end
    wr_rd(8'h0D, 8'hFF, 8'h00, 1'b0);
    wr_rd(8'h0B, r[15:8], r[15:8], 1'b1);
    wr_rd(8'h0C, r[23:16], r[23:16], 1'b1);
    `CHK("source_idle", csr_pkg::CSR_SRC_NORMAL, proc_freq_source)
    for (int s = 0; s < 2; s++) begin
      r = rnd();
      n = r[7:0] | 8'h01;
      strap_frequency_code <= r[20:16];
      software_frequency_code <= r[25:21];
      ratio_source_override <= s[0];
      u_host.wr_pair(n, {s[0], r[14:8] | 7'h01});
      #1;
      `CHK("ratio_code", s[0] ? r[25:21] : r[20:16], ratio_code)
      `CHK("source_before", csr_pkg::CSR_SRC_NORMAL, proc_freq_source)
      `CHK("range_ok", 1'b1, range_ok)
      @(posedge clk_sys);
      watchdog_enable <= 1'b1;
      watchdog_timeout <= 1'b1;
      @(posedge clk_sys);
      watchdog_timeout <= 1'b0;
      #1;
      `CHK("recovery_mode", 1'b1, recovery_mode)
      `CHK("timeout_start", 1'b1, freq_change_start)
      `CHK("source", s[0] ? csr_pkg::CSR_SRC_PROGRAM : csr_pkg::CSR_SRC_STRAP, proc_freq_source)
      if (s == 1) begin
        `CHK("divider", {n, r[14:8] | 7'h01}, {proc_divider_n, proc_divider_m})
      end
      @(posedge clk_sys);
      u_host.wr(8'h0B, n ^ 8'h80);
      #1;
      `CHK("retune_start", s[0], freq_change_start)
      u_host.idle();
      `CHK("lock_held", 1'b1, recovery_mode)
      watchdog_enable <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK("unlock", 1'b0, recovery_mode)
      @(posedge clk_sys);
    end
    // A zero divider must read back and be flagged as out of range.
    wr_rd(csr_pkg::OFS_REC_N, 8'h00, 8'h00, 1'b1);
    `CHK("range_zero", 1'b0, range_ok)
    // Lock, then reset in mid-run: the lock must drop and every register must clear.
    watchdog_enable <= 1'b1;
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
    @(posedge clk_sys);
    `CHK("lock_before_reset", 1'b1, recovery_mode)
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    `CHK("reset_lock", 1'b0, recovery_mode)
    `CHK("reset_range", 1'b0, range_ok)
    @(posedge clk_sys);
    read_zero();
    watchdog_enable <= 1'b0;
    @(posedge clk_sys);
    final_report();
  end
endmodule
